// ---- rtl/interval_wdt_prescaler.sv ----
// slow-oscillator divider with interval, sensor and watchdog taps, apb regs
`timescale 1ns/1ps

// Functional notes
// - watchdog period select picks wd tick
// - sensor select sets mode and period
// - interval select picks interval tick period
// - restart bit restarts divider, clears later
// - restart ignored while watchdog enabled
// - interval irq needs enable and global
// - interval request while flag and enabled
// - flag bits 7..2 read zero
// - second timer tick sets its flag
// - second timer irq needs both enables
// - second flag cleared on entry, w1c
// - 20-stage divider runs from reset
// - 3-bit watchdog counter resets on overflow
// - interval tick sets flag, entry clears
module interval_wdt_prescaler
    import interval_wdt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,                      // freezes all state
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // slow oscillator and system side
    input  wire logic        osc_tick,                // one pclk pulse per slow edge
    input  wire logic        global_irq_enable,       // cpu_status_word i bit
    input  wire logic        second_timer_tick,       // second timer output pulse
    input  wire logic        second_timer_irq_enable,
    input  wire logic        interval_irq_ack,        // interval vector entered
    input  wire logic        second_timer_irq_ack,    // second vector entered
    input  wire logic        wd_kick,                 // watchdog reset instruction
    // outputs
    output logic             interval_tick,
    output logic             motion_sense_tick,
    output logic             motion_sense_active,
    output logic             wd_tick,
    output logic             wd_reset,                // system reset request pulse
    output logic             interval_irq_req,
    output logic             second_timer_irq_req,
    output logic             irq
);

    // -----------------------------------------------------------------
    // register state
    // -----------------------------------------------------------------
    logic [2:0]            interval_sel_reg;    // interval_period_sel
    logic                  irq_enable_reg;      // interval_irq_enable
    logic                  restart_reg;         // divider_restart
    logic [2:0]            sense_sel_reg;       // sense_period_sel
    logic [2:0]            restart_cnt_reg;     // cycles restart bit has stood
    logic [FLG_WIDTH-1:0]  flags_reg;           // shared interrupt flags
    logic [FLG_WIDTH-1:0]  mask_reg;            // irq output mask
    logic [2:0]            wd_sel_reg;          // wd_period_sel
    logic                  wd_enable_reg;       // watchdog enable
    logic [DIV_STAGES-1:0] div_reg;             // slow divider
    logic [WD_CNT_W-1:0]   wd_cnt_reg;          // watchdog counter
    logic                  ack_reg;             // apb read data loaded

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    logic wr_en;       // write taken at this edge
    logic sel_ctl;
    logic sel_flg;
    logic sel_wdc;
    logic sel_msk;
    logic mapped;

    assign sel_ctl = paddr == OFF_TIMER0_CONTROL;
    assign sel_flg = paddr == OFF_TIMER10_FLAGS;
    assign sel_wdc = paddr == OFF_WD_CONTROL;
    assign sel_msk = paddr == OFF_IRQ_MASK;
    assign mapped  = sel_ctl | sel_flg | sel_wdc | sel_msk;

    // answer in the first access cycle; data were loaded during setup
    assign pready  = ack_reg & ce;
    assign pslverr = pready & ~mapped;
    assign wr_en   = psel & penable & pready & pwrite & mapped;

    // read mux, unmapped addresses read zero
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctl) begin
            rd_mux[CTL_INTERVAL_SEL_LSB +: 3] = interval_sel_reg;
            rd_mux[CTL_IRQ_ENABLE_BIT]        = irq_enable_reg;
            rd_mux[CTL_RESTART_BIT]           = restart_reg;
            rd_mux[CTL_SENSE_SEL_LSB +: 3]    = sense_sel_reg;
        end else if (sel_flg) begin
            rd_mux[FLG_WIDTH-1:0] = flags_reg;  // upper bits stay zero
        end else if (sel_wdc) begin
            rd_mux[WDC_PERIOD_LSB +: 3] = wd_sel_reg;
            rd_mux[WDC_ENABLE_BIT]      = wd_enable_reg;
        end else if (sel_msk) begin
            rd_mux[FLG_WIDTH-1:0] = mask_reg;
        end
    end

    // read data register and ready handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            ack_reg <= 1'b0;
        end else if (ce) begin
            if (psel && !ack_reg) begin
                prdata  <= rd_mux;
                ack_reg <= 1'b1;
            end else begin
                ack_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // timer0_control
    // -----------------------------------------------------------------
    logic restart_set;    // software asks for a restart
    logic restart_done;   // hold time elapsed

    assign restart_set  = wr_en & sel_ctl & pwdata[CTL_RESTART_BIT];
    assign restart_done = restart_reg && restart_cnt_reg == RESTART_HOLD_LAST;

    // select fields and interrupt enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval_sel_reg <= CTL_RESET[CTL_INTERVAL_SEL_LSB +: 3];
            irq_enable_reg   <= CTL_RESET[CTL_IRQ_ENABLE_BIT];
            sense_sel_reg    <= CTL_RESET[CTL_SENSE_SEL_LSB +: 3];
        end else if (ce && wr_en && sel_ctl) begin
            interval_sel_reg <= pwdata[CTL_INTERVAL_SEL_LSB +: 3];
            irq_enable_reg   <= pwdata[CTL_IRQ_ENABLE_BIT];
            sense_sel_reg    <= pwdata[CTL_SENSE_SEL_LSB +: 3];
        end
    end

    // restart bit self-clears after the hold time, counted in pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_reg     <= CTL_RESET[CTL_RESTART_BIT];
            restart_cnt_reg <= 3'h0;
        end else if (ce) begin
            if (restart_set) begin
                restart_reg     <= 1'b1;
                restart_cnt_reg <= 3'h0;
            end else if (restart_done) begin
                restart_reg     <= 1'b0;
                restart_cnt_reg <= 3'h0;
            end else if (restart_reg) begin
                restart_cnt_reg <= restart_cnt_reg + 3'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // watchdog control and irq mask
    // -----------------------------------------------------------------
    logic wd_kick_sw;   // software kick via register

    assign wd_kick_sw = wr_en & sel_wdc & pwdata[WDC_KICK_BIT];

    // no timed change sequence here; the field is written directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_sel_reg    <= WDC_RESET[WDC_PERIOD_LSB +: 3];
            wd_enable_reg <= WDC_RESET[WDC_ENABLE_BIT];
        end else if (ce && wr_en && sel_wdc) begin
            wd_sel_reg    <= pwdata[WDC_PERIOD_LSB +: 3];
            wd_enable_reg <= pwdata[WDC_ENABLE_BIT];
        end
    end

    // mask register gating the flags onto irq
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= FLG_RESET;
        end else if (ce && wr_en && sel_msk) begin
            mask_reg <= pwdata[FLG_WIDTH-1:0];
        end
    end

    // -----------------------------------------------------------------
    // slow divider
    // -----------------------------------------------------------------
    logic div_clear;  // restart only while the watchdog is off

    assign div_clear = restart_reg & ~wd_enable_reg;

    // counts from reset release without any software action
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else if (ce) begin
            if (div_clear) begin
                div_reg <= '0;
            end else if (osc_tick) begin
                div_reg <= div_reg + 20'h00001;
            end
        end
    end

    // -----------------------------------------------------------------
    // taps
    // -----------------------------------------------------------------
    logic sense_run;  // sensor mode decoded from its select

    // codes 000 and 111 switch the sensor off
    assign sense_run = (sense_sel_reg != 3'h0) && (sense_sel_reg != 3'h7);
    assign motion_sense_active = sense_run;

    // interval tick, period from interval select
    period_tap u_interval_tap (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .osc_tick (osc_tick & ~div_clear),
        .active   (1'b1),
        .count    (div_reg),
        .exp_sel  (interval_exp(interval_sel_reg)),
        .tick     (interval_tick)
    );

    // sensor tick, silent while the mode is off
    period_tap u_sense_tap (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .osc_tick (osc_tick & ~div_clear),
        .active   (sense_run),
        .count    (div_reg),
        .exp_sel  (sense_exp(sense_sel_reg)),
        .tick     (motion_sense_tick)
    );

    // watchdog tick, only while the watchdog is enabled
    period_tap u_wd_tap (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .osc_tick (osc_tick & ~div_clear),
        .active   (wd_enable_reg),
        .count    (div_reg),
        .exp_sel  (wd_exp(wd_sel_reg)),
        .tick     (wd_tick)
    );

    // -----------------------------------------------------------------
    // watchdog counter: eight wd ticks without a kick give a reset
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_reg <= '0;
            wd_reset   <= 1'b0;
        end else if (ce) begin
            wd_reset <= 1'b0;
            if (!wd_enable_reg || wd_kick || wd_kick_sw) begin
                wd_cnt_reg <= '0;
            end else if (wd_tick) begin
                wd_cnt_reg <= wd_cnt_reg + 3'h1;
                if (wd_cnt_reg == 3'h7) begin
                    wd_reset <= 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // shared interrupt flags, set beats any clear in the same cycle
    // -----------------------------------------------------------------
    logic [FLG_WIDTH-1:0] flg_set;  // hardware events
    logic [FLG_WIDTH-1:0] flg_clr;  // w1c write or vector entry

    assign flg_set[FLG_INTERVAL_BIT] = interval_tick;
    assign flg_set[FLG_SECOND_BIT]   = second_timer_tick;
    assign flg_clr[FLG_INTERVAL_BIT] = interval_irq_ack |
        (wr_en & sel_flg & pwdata[FLG_INTERVAL_BIT]);
    assign flg_clr[FLG_SECOND_BIT]   = second_timer_irq_ack |
        (wr_en & sel_flg & pwdata[FLG_SECOND_BIT]);

    // sticky flags; reserved bits have no storage at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLG_RESET;
        end else if (ce) begin
            flags_reg <= flg_set | (flags_reg & ~flg_clr);
        end
    end

    // -----------------------------------------------------------------
    // interrupt requests toward the processor
    // -----------------------------------------------------------------
    assign interval_irq_req = flags_reg[FLG_INTERVAL_BIT] & irq_enable_reg &
                              global_irq_enable;
    assign second_timer_irq_req = flags_reg[FLG_SECOND_BIT] &
                                  second_timer_irq_enable &
                                  global_irq_enable;
    // level output for an interrupt controller, gated by the mask register
    assign irq = |(flags_reg & mask_reg);

endmodule

// ---- rtl/interval_wdt_pkg.sv ----
// constants, field layout and period tables of the interval/watchdog prescaler
package interval_wdt_pkg;

    // -----------------------------------------------------------------
    // register byte offsets on the apb side
    // -----------------------------------------------------------------
    localparam logic [7:0] OFF_TIMER0_CONTROL = 8'h00;
    localparam logic [7:0] OFF_TIMER10_FLAGS  = 8'h04;
    localparam logic [7:0] OFF_WD_CONTROL     = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h0c;

    // -----------------------------------------------------------------
    // timer0_control fields
    // -----------------------------------------------------------------
    localparam int CTL_INTERVAL_SEL_LSB = 0;  // interval_period_sel [2:0]
    localparam int CTL_IRQ_ENABLE_BIT   = 3;  // interval_irq_enable
    localparam int CTL_RESTART_BIT      = 4;  // divider_restart
    localparam int CTL_SENSE_SEL_LSB    = 5;  // sense_period_sel [7:5]
    localparam logic [7:0] CTL_RESET    = 8'h00;

    // -----------------------------------------------------------------
    // timer10_interrupt_flags fields (bits 7..2 reserved, read zero)
    // -----------------------------------------------------------------
    localparam int FLG_INTERVAL_BIT  = 0;
    localparam int FLG_SECOND_BIT    = 1;
    localparam int FLG_WIDTH         = 2;
    localparam logic [1:0] FLG_RESET = 2'h0;

    // -----------------------------------------------------------------
    // wd_control fields
    // -----------------------------------------------------------------
    localparam int WDC_PERIOD_LSB    = 0;  // wd_period_sel [2:0]
    localparam int WDC_ENABLE_BIT    = 3;  // watchdog enable
    localparam int WDC_KICK_BIT      = 4;  // write one restarts wd counter
    localparam logic [3:0] WDC_RESET = 4'h0;

    // -----------------------------------------------------------------
    // divider geometry and timing
    // -----------------------------------------------------------------
    localparam int DIV_STAGES            = 20;
    localparam int EXP_W                 = 5;
    localparam int WD_CNT_W              = 3;
    localparam int RESTART_HOLD_CYCLES   = 4;  // auto clear of restart bit
    localparam logic [2:0] RESTART_HOLD_LAST = 3'(RESTART_HOLD_CYCLES - 1);

    // interval tap: 8,32,128,1K,4K,32K,256K,1024K slow cycles
    function automatic logic [4:0] interval_exp(input logic [2:0] sel);
        logic [4:0] e;
        e = 5'h03;
        unique case (sel)
            3'h0: e = 5'h03;
            3'h1: e = 5'h05;
            3'h2: e = 5'h07;
            3'h3: e = 5'h0a;
            3'h4: e = 5'h0c;
            3'h5: e = 5'h0f;
            3'h6: e = 5'h12;
            3'h7: e = 5'h14;
        endcase
        return e;
    endfunction

    // watchdog tap: 1K,2K,4K,8K,32K,64K,256K,512K slow cycles
    function automatic logic [4:0] wd_exp(input logic [2:0] sel);
        logic [4:0] e;
        e = 5'h0a;
        unique case (sel)
            3'h0: e = 5'h0a;
            3'h1: e = 5'h0b;
            3'h2: e = 5'h0c;
            3'h3: e = 5'h0d;
            3'h4: e = 5'h0f;
            3'h5: e = 5'h10;
            3'h6: e = 5'h12;
            3'h7: e = 5'h13;
        endcase
        return e;
    endfunction

    // sensor tap: off,32K,64K,128K,256K,512K,32 (test),off
    function automatic logic [4:0] sense_exp(input logic [2:0] sel);
        logic [4:0] e;
        e = 5'h0f;
        unique case (sel)
            3'h1: e = 5'h0f;
            3'h2: e = 5'h10;
            3'h3: e = 5'h11;
            3'h4: e = 5'h12;
            3'h5: e = 5'h13;
            3'h6: e = 5'h05;
            default: e = 5'h0f;
        endcase
        return e;
    endfunction

endpackage

// ---- rtl/period_tap.sv ----
// one selectable tap of the slow divider, giving a one-cycle tick per period
`timescale 1ns/1ps
module period_tap
    import interval_wdt_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  osc_tick,  // slow oscillator edge
    input  wire logic                  active,    // tap allowed to fire
    input  wire logic [DIV_STAGES-1:0] count,     // divider state before edge
    input  wire logic [EXP_W-1:0]      exp_sel,   // period is 2**exp_sel
    output logic                       tick       // one pclk cycle per period
);

    // -----------------------------------------------------------------
    // period mask and terminal detect
    // -----------------------------------------------------------------
    logic [DIV_STAGES:0]   wide_mask;  // one bit wider so exp 20 fits
    logic [DIV_STAGES-1:0] mask;       // low exp_sel bits set
    logic                  terminal;   // low bits all ones at this edge

    assign wide_mask = (21'h000001 << exp_sel) - 21'h000001;
    assign mask      = wide_mask[DIV_STAGES-1:0];
    assign terminal  = (count & mask) == mask;

    // tick registered so the output is glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else if (ce) begin
            tick <= active & osc_tick & terminal;
        end
    end

endmodule

// ---- verif/interval_wdt_prescaler_chk.sv ----
// port-level checker of the interval/watchdog prescaler
`timescale 1ns/1ps
module interval_wdt_prescaler_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_tick,
    input wire logic global_irq_enable,
    input wire logic second_timer_tick,
    input wire logic second_timer_irq_enable,
    input wire logic second_timer_irq_ack,
    input wire logic interval_irq_ack,
    input wire logic interval_tick,
    input wire logic interval_irq_req,
    input wire logic second_timer_irq_req,
    input wire logic motion_sense_tick,
    input wire logic motion_sense_active,
    input wire logic wd_tick,
    input wire logic wd_reset
);
    // -------------------------------------------------------------
    // one clock domain, so one default clock and disable
    // -------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero wait states: a stalled slave would hang software polls
    AST_PREADY: assert property (psel && penable && ce |-> pready)
        else $error("no ready in access cycle");
    AST_SLVERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_INT_TICK: assert property (interval_tick |-> $past(osc_tick) ##1 !interval_tick)
        else $error("interval tick without slow edge");
    AST_INT_REQ: assert property (interval_irq_req |-> global_irq_enable)
        else $error("interval request with global off");
    AST_INT_ACK: assert property (interval_irq_ack && !interval_tick |=> !interval_irq_req)
        else $error("interval flag kept after entry");
    AST_SEC_SET: assert property (second_timer_tick && second_timer_irq_enable
        && global_irq_enable && ce ##1 second_timer_irq_enable && global_irq_enable
        |-> second_timer_irq_req)
        else $error("second timer tick did not raise request");
    AST_SEC_REQ: assert property (second_timer_irq_req |->
        second_timer_irq_enable && global_irq_enable)
        else $error("second request without both enables");
    AST_SEC_ACK: assert property (second_timer_irq_ack && !second_timer_tick
        |=> !second_timer_irq_req)
        else $error("second flag kept after entry");
    AST_SENSE: assert property (motion_sense_tick |->
        $past(motion_sense_active) && $past(osc_tick))
        else $error("sensor tick while sensor off");
    AST_WD_RST: assert property (wd_reset |-> $past(wd_tick) ##1 !wd_reset)
        else $error("watchdog reset not after a tick");
    AST_WD_TICK: assert property (wd_tick |-> $past(osc_tick))
        else $error("watchdog tick without slow edge");
endmodule

bind interval_wdt_prescaler interval_wdt_prescaler_chk i_chk (.*);

// ---- verif/interval_wdt_prescaler_tb_top.sv ----
// self-checking bench of the interval/watchdog prescaler
`timescale 1ns/1ps
module interval_wdt_prescaler_tb_top;
    import interval_wdt_pkg::*;
    // -------------------------------------------------------------
    // stimulus and observed signals, named as the design ports
    // -------------------------------------------------------------
    logic pclk, presetn, ce, psel, penable, pwrite, osc_tick, wd_kick;
    logic global_irq_enable, second_timer_tick, second_timer_irq_enable;
    logic interval_irq_ack, second_timer_irq_ack;
    logic pready, pslverr, interval_tick, motion_sense_tick, motion_sense_active;
    logic wd_tick, wd_reset, interval_irq_req, second_timer_irq_req, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [2:0]  tk;
    int mismatches, comparisons, cnt[3], per[3], nt[3], s, n;
    int ip[5] = '{8, 32, 128, 1024, 4096};  // interval periods of codes 0..4

    interval_wdt_prescaler i_dut (.*);

    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end

    // slow oscillator edges arrive at random, about three cycles in four
    always @(posedge pclk) osc_tick <= ($urandom % 4) != 0;

    // -------------------------------------------------------------
    // period monitor: slow edges counted between two ticks
    // -------------------------------------------------------------
    assign tk = {wd_tick, motion_sense_tick, interval_tick};
    always @(posedge pclk)
        for (int i = 0; i < 3; i++) begin
            if (tk[i] === 1'b1) begin
                per[i] = cnt[i];
                cnt[i] = osc_tick;
                nt[i]++;
            end else
                cnt[i] += osc_tick;
        end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        if (k >= 50) mismatches++;  // no answer in time
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // bounded wait for k further ticks of monitor lane i
    task automatic wait_tick(input int i, input int k);
        int m;
        m = nt[i] + k;
        for (int j = 0; j < 40000 && nt[i] < m; j++) begin
            @(posedge pclk);
            #1;
        end
        if (nt[i] < m) mismatches++;  // ticks never came
    endtask

    // one-cycle pulse on the lines picked by m: kick, tick, interval ack, second ack
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        {wd_kick, second_timer_tick, interval_irq_ack, second_timer_irq_ack} <= m;
        @(posedge pclk);
        {wd_kick, second_timer_tick, interval_irq_ack, second_timer_irq_ack} <= 4'h0;
        @(posedge pclk);
        #1;
    endtask

    task end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, well beyond the expected run length
    initial begin
        #2250000;
        mismatches++;
        end_of_test;
    end

    initial begin
        void'($urandom(32'h20842b49));
        {psel, penable, pwrite, wd_kick, global_irq_enable} = '0;
        {second_timer_tick, second_timer_irq_enable, interval_irq_ack} = '0;
        {second_timer_irq_ack, paddr, pwdata} = '0;
        ce = 1;
        presetn = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        // ---------------------------------------------------------
        // reset values, unmapped place, random read-back
        // ---------------------------------------------------------
        apb(0, OFF_TIMER0_CONTROL, 0);
        chk(rd, 32'h0);
        apb(0, OFF_TIMER10_FLAGS, 0);
        chk(rd, 32'h0);
        apb(0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        v = $urandom & 32'h000000ef;
        apb(1, OFF_TIMER0_CONTROL, v);
        apb(0, OFF_TIMER0_CONTROL, 0);
        chk(rd, v);
        // sensor select cleared in the same write as every restart below
        for (int c = 0; c < 5; c++) begin
            apb(1, OFF_TIMER0_CONTROL, 32'h10 | c);
            wait_tick(0, 3);
            chk(per[0], ip[c]);
        end
        // ---------------------------------------------------------
        // restart mid-period, then the same with watchdog on
        // ---------------------------------------------------------
        apb(1, OFF_TIMER0_CONTROL, 32'h03);
        wait_tick(0, 1);
        repeat (600) @(posedge pclk);
        apb(1, OFF_TIMER0_CONTROL, 32'h13);
        apb(0, OFF_TIMER0_CONTROL, 0);
        chk(rd, 32'h13);
        apb(0, OFF_TIMER0_CONTROL, 0);
        chk(rd, 32'h03);
        wait_tick(0, 1);
        chk(per[0] > 1024, 1);
        apb(1, OFF_WD_CONTROL, 32'h08);
        repeat (600) @(posedge pclk);
        apb(1, OFF_TIMER0_CONTROL, 32'h13);
        wait_tick(0, 1);
        chk(per[0], 1024);
        // ---------------------------------------------------------
        // watchdog periods, kick and overflow after eight ticks
        // ---------------------------------------------------------
        wait_tick(2, 2);
        chk(per[2], 1024);
        pulse(4'h8);
        s = nt[2];
        for (n = 0; n < 20000 && wd_reset !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
        end
        chk(nt[2] - s, 8);
        apb(1, OFF_WD_CONTROL, 32'h09);
        wait_tick(2, 2);
        chk(per[2], 2048);
        apb(1, OFF_WD_CONTROL, 32'h00);
        // every sensor code: mode, then the test period
        for (int c = 0; c < 8; c++) begin
            apb(1, OFF_TIMER0_CONTROL, c << 5);
            chk(motion_sense_active, c > 0 && c < 7);
        end
        apb(1, OFF_TIMER0_CONTROL, 32'hc0);
        wait_tick(1, 2);
        chk(per[1], 32);
        // ---------------------------------------------------------
        // interval interrupt: set, gate, mask, clear
        // ---------------------------------------------------------
        apb(1, OFF_TIMER0_CONTROL, 32'h0c);
        apb(1, OFF_IRQ_MASK, 32'h1);
        @(posedge pclk) global_irq_enable <= 1;
        wait_tick(0, 1);
        pulse(4'h1);
        chk({interval_irq_req, irq}, 2'b11);
        apb(0, OFF_TIMER10_FLAGS, 0);
        chk(rd, 32'h1);
        @(posedge pclk) global_irq_enable <= 0;
        pulse(4'h8);
        chk(interval_irq_req, 0);
        @(posedge pclk) global_irq_enable <= 1;
        apb(1, OFF_TIMER0_CONTROL, 32'h04);
        chk({interval_irq_req, irq}, 2'b01);
        apb(1, OFF_IRQ_MASK, 32'h0);
        chk(irq, 0);
        apb(1, OFF_TIMER10_FLAGS, 32'hfd);
        apb(0, OFF_TIMER10_FLAGS, 0);
        chk(rd, 32'h0);
        wait_tick(0, 1);
        pulse(4'h2);
        apb(0, OFF_TIMER10_FLAGS, 0);
        chk(rd, 32'h0);
        // ---------------------------------------------------------
        // second timer flag: tick, entry clear, write-one clear
        // ---------------------------------------------------------
        @(posedge pclk) second_timer_irq_enable <= 1;
        pulse(4'h4);
        chk(second_timer_irq_req, 1);
        apb(1, OFF_IRQ_MASK, 32'h2);
        chk(irq, 1);
        pulse(4'h1);
        chk(second_timer_irq_req, 0);
        pulse(4'h4);
        apb(1, OFF_TIMER10_FLAGS, 32'h2);
        apb(0, OFF_TIMER10_FLAGS, 0);
        chk(rd[1], 0);
        end_of_test;
    end
endmodule
